// ---- logic/afp_ctrl.sv ----
`include "afp_defs.svh"
`default_nettype none
// Overview of operation
// - Over-current tri-states outputs, asserts fault report low and latches.
// - Die over-temperature shuts down, asserts fault report and latches.
// - Either channel above 60% duty one polarity beyond 420 ms raises DC fault.
// - DC fault asserts fault report, tri-states outputs and latches.
// - Supply below 4.5 V tri-states outputs silently; recovers by itself.
// - Supply above 27 V tri-states outputs silently; recovers by itself.
// - Taking shutdown input low clears latched faults.
// - Fault report wired to shutdown input gives automatic restart.
// - Leaving shutdown passes a 10 ms power-up interval before amplifying.
// - Shutdown input low mutes outputs and enters low-current state.
module afp_ctrl
    import afp_pkg::*;
#(
    parameter int unsigned POWERUP_CYC = `AFP_POWERUP_CYC,
    parameter int unsigned DC_PERSIST_CYC = `AFP_DC_PERSIST_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic shutdown_low_in,
    input wire afp_sense_s sense_in,
    input wire afp_pwm_s pwm_in,
    output logic fault_report_low,
    output logic outputs_hiz,
    output logic amp_enable,
    output logic low_current,
    output logic [2:0] latched_faults
);
    afp_sense_s sense_m_q, sense_q;
    afp_pwm_s pwm_m_q, pwm_q;
    logic shut_low_m_q, shut_low_q;
    afp_state_e state_q, state_d;
    logic [2:0] latch_q, latch_d;
    logic [31:0] pu_q, pu_d;
    logic dc_l, dc_r, supply_bad, new_fault, detect_en;
    logic [31:0] pu_seen_q, pu_seen_d, run_seen_q, run_seen_d;

    // One place decides what counts as a live latched fault
    function automatic logic any_fault(input logic [2:0] flags);
        return flags != 3'h0;
    endfunction

    // Pins are asynchronous; two flops before any logic looks at them
    always_ff @(posedge clk) begin
        if (rst) begin
            sense_m_q <= '0;
            sense_q <= '0;
            pwm_m_q <= '0;
            pwm_q <= '0;
            shut_low_m_q <= 1'b0;
            shut_low_q <= 1'b0;
        end else begin
            sense_m_q <= sense_in;
            sense_q <= sense_m_q;
            pwm_m_q <= pwm_in;
            pwm_q <= pwm_m_q;
            shut_low_m_q <= shutdown_low_in;
            shut_low_q <= shut_low_m_q;
        end
    end

    // DC watch only runs while amplifying, so start-up transients do not count
    assign detect_en = (state_q == AFP_RUN) && !supply_bad;

    afp_dc_detect #(.PERSIST_CYC(DC_PERSIST_CYC)) u_dc_l (
        .clk(clk),
        .rst(rst),
        .enable(detect_en),
        .out_p(pwm_q.pos_l),
        .out_n(pwm_q.neg_l),
        .dc_fault(dc_l)
    );

    afp_dc_detect #(.PERSIST_CYC(DC_PERSIST_CYC)) u_dc_r (
        .clk(clk),
        .rst(rst),
        .enable(detect_en),
        .out_p(pwm_q.pos_r),
        .out_n(pwm_q.neg_r),
        .dc_fault(dc_r)
    );

    assign supply_bad = sense_q.under_volt | sense_q.over_volt;

    always_comb begin
        state_d = state_q;
        pu_d = pu_q;
        latch_d = latch_q;
        if (!shut_low_q) begin
            // Clearing by shutdown wins; a fault present at release is caught again
            latch_d = 3'h0;
            state_d = AFP_SHUT;
            pu_d = 32'h0000_0000;
        end else begin
            if (state_q != AFP_SHUT) begin
                latch_d[`AFP_FLT_OC] = latch_q[`AFP_FLT_OC] | sense_q.over_current;
                latch_d[`AFP_FLT_OT] = latch_q[`AFP_FLT_OT] | sense_q.over_temp;
                latch_d[`AFP_FLT_DC] = latch_q[`AFP_FLT_DC] | dc_l | dc_r;
            end
            unique case (state_q)
                AFP_SHUT: begin
                    state_d = AFP_POWERUP;
                    pu_d = 32'h0000_0000;
                end
                AFP_POWERUP: begin
                    if (any_fault(latch_d)) state_d = AFP_FAULT;
                    else if (pu_q >= POWERUP_CYC - 1) state_d = AFP_RUN;
                    else pu_d = pu_q + 32'h0000_0001;
                end
                AFP_RUN: begin
                    if (any_fault(latch_d)) state_d = AFP_FAULT;
                end
                AFP_FAULT: begin
                    state_d = AFP_FAULT;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= AFP_SHUT;
            latch_q <= 3'h0;
            pu_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            latch_q <= latch_d;
            pu_q <= pu_d;
        end
    end

    assign new_fault = any_fault(latch_q);
    // Fault report carries only latched faults; supply faults stay silent
    assign fault_report_low = !new_fault;
    assign amp_enable = (state_q == AFP_RUN) && !supply_bad && !new_fault;
    assign outputs_hiz = !amp_enable;
    assign low_current = (state_q == AFP_SHUT);
    assign latched_faults = latch_q;

    // Checker-only counters, kept apart from the control path so a slip there shows up
    always_comb begin
        pu_seen_d = 32'h0000_0000;
        run_seen_d = 32'h0000_0000;
        if (state_q == AFP_POWERUP) pu_seen_d = pu_seen_q + 32'h0000_0001;
        if (detect_en) begin
            run_seen_d = run_seen_q;
            // Saturates so a long clean run cannot wrap back under the threshold
            if (run_seen_q < DC_PERSIST_CYC) run_seen_d = run_seen_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pu_seen_q <= 32'h0000_0000;
            run_seen_q <= 32'h0000_0000;
        end else begin
            pu_seen_q <= pu_seen_d;
            run_seen_q <= run_seen_d;
        end
    end

    // Timing checks lean on the counters above rather than on the control counter
    rpt_on_latch_a: assert property (@(posedge clk) disable iff (rst)
        (latch_q != 3'h0) |-> state_q == AFP_FAULT && !fault_report_low && outputs_hiz)
        else $error("fault not reported");
    oc_latch_a: assert property (@(posedge clk) disable iff (rst)
        shut_low_q && state_q != AFP_SHUT && sense_q.over_current |=> latch_q[`AFP_FLT_OC] && !fault_report_low)
        else $error("over-current lost");
    ot_latch_a: assert property (@(posedge clk) disable iff (rst)
        shut_low_q && state_q != AFP_SHUT && sense_q.over_temp |=> latch_q[`AFP_FLT_OT])
        else $error("thermal lost");
    ot_report_a: assert property (@(posedge clk) disable iff (rst)
        shut_low_q && state_q != AFP_SHUT && sense_q.over_temp |=> !fault_report_low && outputs_hiz)
        else $error("thermal not reported");
    dc_early_a: assert property (@(posedge clk) disable iff (rst)
        dc_l || dc_r |-> run_seen_q >= DC_PERSIST_CYC)
        else $error("dc fault too early");
    dc_quiet_a: assert property (@(posedge clk) disable iff (rst)
        !detect_en |=> !dc_l && !dc_r)
        else $error("dc watch not idle");
    dc_latch_a: assert property (@(posedge clk) disable iff (rst)
        shut_low_q && (dc_l || dc_r) && state_q == AFP_RUN |=> latch_q[`AFP_FLT_DC])
        else $error("dc lost");
    dc_report_a: assert property (@(posedge clk) disable iff (rst)
        latch_q[`AFP_FLT_DC] |-> !fault_report_low && outputs_hiz)
        else $error("dc not reported");
    uv_silent_a: assert property (@(posedge clk) disable iff (rst)
        sense_q.under_volt && latch_q == 3'h0 |-> fault_report_low && outputs_hiz)
        else $error("uv wrong");
    ov_silent_a: assert property (@(posedge clk) disable iff (rst)
        sense_q.over_volt && latch_q == 3'h0 |-> fault_report_low && outputs_hiz)
        else $error("ov wrong");
    supply_resume_a: assert property (@(posedge clk) disable iff (rst)
        state_q == AFP_RUN && !supply_bad && latch_q == 3'h0 |-> amp_enable)
        else $error("no resume after supply");
    clear_on_shut_a: assert property (@(posedge clk) disable iff (rst)
        !shut_low_q |=> latch_q == 3'h0 && low_current)
        else $error("latch not cleared");
    fault_hold_a: assert property (@(posedge clk) disable iff (rst)
        state_q == AFP_FAULT && shut_low_q |=> state_q == AFP_FAULT && latch_q != 3'h0)
        else $error("latch dropped");
    pu_hold_a: assert property (@(posedge clk) disable iff (rst)
        state_q == AFP_SHUT && shut_low_q |=> !amp_enable [*8])
        else $error("power-up skipped");
    pu_len_a: assert property (@(posedge clk) disable iff (rst)
        state_q == AFP_POWERUP && state_d == AFP_RUN |-> pu_seen_q == 32'(POWERUP_CYC - 1))
        else $error("power-up length");
    shut_mute_a: assert property (@(posedge clk) disable iff (rst)
        !shut_low_q |=> outputs_hiz)
        else $error("not muted");
    shut_clean_a: assert property (@(posedge clk) disable iff (rst)
        state_q == AFP_SHUT |-> latch_q == 3'h0 && fault_report_low && !amp_enable)
        else $error("shut not clean");
    oc_recheck_a: assert property (@(posedge clk) disable iff (rst)
        state_q == AFP_POWERUP && shut_low_q && sense_q.over_current |=> state_q == AFP_FAULT)
        else $error("recheck");
    ot_recheck_a: assert property (@(posedge clk) disable iff (rst)
        state_q == AFP_POWERUP && shut_low_q && sense_q.over_temp |=> state_q == AFP_FAULT && latch_q[`AFP_FLT_OT])
        else $error("thermal recheck");
endmodule
`default_nettype wire

// ---- inc/afp_defs.svh ----
`ifndef AFP_DEFS_SVH
`define AFP_DEFS_SVH

// Clock rate and timing figures
`define AFP_CLK_HZ 20000000
`define AFP_DC_PERSIST_MS 420
`define AFP_POWERUP_MS 10
`define AFP_DC_PERSIST_CYC ((`AFP_DC_PERSIST_MS * (`AFP_CLK_HZ / 1000)) + 1)
`define AFP_POWERUP_CYC (`AFP_POWERUP_MS * (`AFP_CLK_HZ / 1000))

// Duty threshold in percent and duty sample window in cycles
`define AFP_DUTY_PCT 60
`define AFP_DUTY_WIN 100

// Latched fault bit positions
`define AFP_FLT_OC 0
`define AFP_FLT_OT 1
`define AFP_FLT_DC 2

`endif

// ---- inc/afp_pkg.sv ----
`default_nettype none
package afp_pkg;
    typedef enum logic [1:0] {AFP_SHUT, AFP_POWERUP, AFP_RUN, AFP_FAULT} afp_state_e;

    typedef struct packed {
        logic over_current;
        logic over_temp;
        logic under_volt;
        logic over_volt;
    } afp_sense_s;

    typedef struct packed {
        logic pos_l;
        logic neg_l;
        logic pos_r;
        logic neg_r;
    } afp_pwm_s;
endpackage
`default_nettype wire

// ---- logic/afp_dc_detect.sv ----
`include "afp_defs.svh"
`default_nettype none
// Persistent one-polarity duty watcher for one channel.
module afp_dc_detect
    import afp_pkg::*;
#(
    parameter int unsigned PERSIST_CYC = `AFP_DC_PERSIST_CYC,
    parameter int unsigned WIN = `AFP_DUTY_WIN,
    parameter int unsigned PCT = `AFP_DUTY_PCT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic out_p,
    input wire logic out_n,
    output logic dc_fault
);
    localparam int unsigned THR = (WIN * PCT) / 100;
    logic [15:0] win_q, win_d, pos_q, pos_d, neg_q, neg_d;
    logic [31:0] per_q, per_d;
    logic [1:0] pol_q, pol_d;

    // Judges the window just finished; polarity 1 = positive, 2 = negative
    always_comb begin
        win_d = win_q + 16'h0001;
        pos_d = pos_q + {15'h0000, out_p & ~out_n};
        neg_d = neg_q + {15'h0000, out_n & ~out_p};
        pol_d = pol_q;
        per_d = per_q;
        if (!enable) begin
            win_d = 16'h0000;
            pos_d = 16'h0000;
            neg_d = 16'h0000;
            pol_d = 2'h0;
            per_d = 32'h0000_0000;
        end else begin
            if (win_q == 16'(WIN - 1)) begin
                win_d = 16'h0000;
                pos_d = 16'h0000;
                neg_d = 16'h0000;
                if (pos_q > 16'(THR)) pol_d = 2'h1;
                else if (neg_q > 16'(THR)) pol_d = 2'h2;
                else pol_d = 2'h0;
                // A polarity swap restarts the persistence count
                if (pol_d != pol_q) per_d = 32'h0000_0000;
            end
            if (pol_q != 2'h0 && per_d < PERSIST_CYC) per_d = per_d + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            win_q <= 16'h0000;
            pos_q <= 16'h0000;
            neg_q <= 16'h0000;
            pol_q <= 2'h0;
            per_q <= 32'h0000_0000;
        end else begin
            win_q <= win_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
            pol_q <= pol_d;
            per_q <= per_d;
        end
    end

    assign dc_fault = (per_q >= PERSIST_CYC);
endmodule
`default_nettype wire

// ---- sim/afp_host.sv ----
`default_nettype none
module afp_host (
    input wire logic fault_report_low,
    input wire logic tie_en,
    input wire logic cmd_low,
    output logic shutdown_low_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Tied mode lets the fault report pull shutdown low and restart the device
    assign shutdown_low_in = tie_en ? fault_report_low : cmd_low;
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`default_nettype none
module testbench import afp_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PU = 20;
    localparam int DC = 300;
    logic clk, rst, tie, cmd, flt, hiz, en, lowc;
    wire logic shut_low;
    afp_sense_s sense;
    afp_pwm_s pwm;
    logic [2:0] lat;
    logic [31:0] r;
    int n_fail, cmp_count, seed, n;

    afp_ctrl #(.POWERUP_CYC(PU), .DC_PERSIST_CYC(DC)) i_afp_ctrl (.clk(clk), .rst(rst),
        .shutdown_low_in(shut_low), .sense_in(sense), .pwm_in(pwm), .fault_report_low(flt),
        .outputs_hiz(hiz), .amp_enable(en), .low_current(lowc), .latched_faults(lat));
    afp_host i_afp_host (.fault_report_low(flt), .tie_en(tie), .cmd_low(cmd), .shutdown_low_in(shut_low));

    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end

    function logic in_win(int c, int lo, int hi);
        return c >= lo && c <= hi;
    endfunction

    task chk(input logic c, input string m);
        cmp_count++;
        if (c !== 1'b1) begin
            n_fail++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask

    task cyc(int k);
        repeat (k) @(negedge clk);
    endtask

    // Bounded wait on amp_enable (sel 0) or fault report (sel 1); n gives cycles taken
    task wt(input int sel, input logic v);
        n = 0;
        while (((sel == 0) ? en : flt) !== v && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task clear_restart();
        cmd = 0;
        cyc(5);
        chk(lat === 3'h0 && lowc === 1 && flt === 1 && hiz === 1, "clear");
        cmd = 1;
        wt(0, 1);
        chk(in_win(n, PU, PU + 6), "restart");
    endtask

    task end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        n_fail++;
        end_sim();
    end

    initial begin
        rst = 1; tie = 0; cmd = 0; sense = '0; pwm = '0; seed = 50;
        cyc(6);
        rst = 0;
        cyc(1);
        chk(lowc === 1 && flt === 1 && hiz === 1 && en === 0, "reset");
        cmd = 1;
        wt(0, 1);
        chk(in_win(n, PU, PU + 6), "powerup");
        $display("test powerup done");
        for (int i = 0; i < 2; i++) begin
            sense = i ? 4'h4 : 4'h8;
            wt(1, 0);
            chk(n <= 4 && hiz === 1 && lat === (3'h1 << i), "latch");
            sense = '0;
            cyc(10);
            chk(flt === 0 && en === 0, "held");
            clear_restart();
        end
        $display("test latch done");
        // Fault present through shutdown: ignored while shut, caught again on release
        cmd = 0;
        sense = 4'h8;
        cyc(6);
        chk(flt === 1 && lat === 3'h0, "shut refuses");
        cmd = 1;
        wt(1, 0);
        chk(n <= 8 && lat[0] === 1, "relatch");
        sense = '0;
        clear_restart();
        $display("test recheck done");
        for (int i = 0; i < 2; i++) begin
            sense = i ? 4'h1 : 4'h2;
            cyc(3);
            chk(hiz === 1 && en === 0 && flt === 1, "supply");
            sense = '0;
            wt(0, 1);
            chk(n <= 3 && flt === 1 && lat === 3'h0, "resume");
        end
        $display("test supply done");
        repeat (600) begin
            r = $random(seed);
            pwm = {r[0], ~r[0], r[1], ~r[1]};
            @(negedge clk);
        end
        chk(flt === 1 && lat === 3'h0, "no dc");
        // Polarity swapping every 200 cycles must restart the persistence count each time
        repeat (3) begin
            pwm = 4'h8;
            cyc(200);
            pwm = 4'h4;
            cyc(200);
        end
        pwm = '0;
        cyc(150);
        chk(flt === 1 && lat === 3'h0 && en === 1, "swap no dc");
        // Left channel positive, right channel negative
        for (int i = 0; i < 2; i++) begin
            pwm = i ? 4'h1 : 4'h8;
            wt(1, 0);
            chk(in_win(n, DC, DC + 400) && lat === 3'h4 && hiz === 1, "dc");
            pwm = '0;
            clear_restart();
        end
        $display("test dc done");
        tie = 1;
        sense = 4'h8;
        wt(1, 0);
        sense = '0;
        wt(0, 1);
        chk(in_win(n, PU, PU + 20) && lat === 3'h0, "auto restart");
        tie = 0;
        $display("test tied done");
        end_sim();
    end
endmodule
`default_nettype wire
